/* File: hw/panel_timing.sv */
// register file and line and frame timing of the panel controller
`timescale 1ns/1ns
`default_nettype none
`include "panel_timing_defines.svh"
module panel_timing (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             line_sync_output,
  output logic             frame_sync_output,
  output logic             display_enable,
  output logic [16:0]      fetch_address
);
  logic [31:0] regs [0:10];
  logic [31:0] next_regs [0:10];
  logic [7:0]  aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0]  w_strb, next_w_strb;
  logic        aw_held, next_aw_held;
  logic        w_held, next_w_held;
  logic        bvalid, next_bvalid;
  logic [1:0]  bresp, next_bresp;
  logic        rvalid, next_rvalid;
  logic [31:0] rdata, next_rdata;
  logic [1:0]  rresp, next_rresp;
  logic [10:0] hcount, next_hcount;
  logic [10:0] vcount, next_vcount;
  logic        de, next_de;
  logic [16:0] faddr, next_faddr;
  logic        aw_free, next_aw_free;
  logic        w_free, next_w_free;
  logic        ar_free, next_ar_free;
  logic [10:0] htot, horiz_display_period, hds, line_sync_start, line_sync_width, vtot, vert_display_period, vds, frame_sync_start, vpw;
  logic        hpol, vpol, line_raw, frame_raw, wr_go;
  logic [3:0]  widx;
  logic        wmapped;
  panel_timing_pkg::panel_e ptype;

  function automatic logic [3:0] decode(input logic [7:0] a, output logic ok);
    ok = 1'b1;
    unique case (a & 8'hfc)
      `OFS_HTOTAL:     decode = 4'h0;
      `OFS_HDISP:      decode = 4'h1;
      `OFS_HSTART:     decode = 4'h2;
      `OFS_LINE_SYNC:  decode = 4'h3;
      `OFS_VTOTAL:     decode = 4'h4;
      `OFS_VDISP:      decode = 4'h5;
      `OFS_VSTART:     decode = 4'h6;
      `OFS_FRAME_SYNC: decode = 4'h7;
      `OFS_MAIN_ADDR:  decode = 4'h8;
      `OFS_PANEL_CTRL: decode = 4'h9;
      `OFS_STATUS:     decode = 4'ha;
      default: begin
        decode = 4'h0;
        ok = 1'b0;
      end
    endcase
  endfunction

  // field decode; units converted to pixel counts once here
  always_comb begin
    htot  = {regs[0][6:0], 3'b111} + 11'd1;
    horiz_display_period   = {regs[1][6:0], 3'b111} + 11'd1;
    hds   = {1'b0, regs[2][9:0]};
    line_sync_start   = {1'b0, regs[3][9:0]} + 11'd1;
    line_sync_width   = {4'b0, regs[3][22:16]} + 11'd1;
    hpol  = regs[3][`POL_BIT];
    vtot  = {1'b0, regs[4][9:0]} + 11'd1;
    vert_display_period   = {1'b0, regs[5][9:0]} + 11'd1;
    vds   = {1'b0, regs[6][9:0]};
    frame_sync_start   = {1'b0, regs[7][9:0]};
    vpw   = {8'b0, regs[7][18:16]} + 11'd1;
    vpol  = regs[7][`POL_BIT];
    ptype = panel_timing_pkg::panel_e'(regs[9][1:0]);
  end

  // axi write: address and data latched independently, response after both
  always_comb begin
    for (int i = 0; i < 11; i++) begin
      next_regs[i] = regs[i];
    end
    next_aw_addr = aw_addr;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    if (s_axi_awvalid && !aw_held) begin
      next_aw_addr = s_axi_awaddr;
      next_aw_held = 1'b1;
    end
    if (s_axi_wvalid && !w_held) begin
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
      next_w_held = 1'b1;
    end
    wr_go = aw_held && w_held && !bvalid;
    widx  = decode(aw_addr, wmapped);
    if (wr_go) begin
      // status word is read only
      if (wmapped && widx != 4'ha) begin
        for (int b = 0; b < 4; b++) begin
          if (w_strb[b]) begin
            next_regs[widx][8*b +: 8] = w_data[8*b +: 8];
          end
        end
      end
      next_bresp   = wmapped ? 2'b00 : 2'b10;
      next_bvalid  = 1'b1;
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
    end
    if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    next_regs[10] = {14'b0, (vcount >= vds + vert_display_period) || (vcount < vds), de, 5'b0, vcount};
    // ready leaves its own flop, not an inverter, so the port is glitch free
    next_aw_free  = !next_aw_held;
    next_w_free   = !next_w_held;
  end

  // axi read: one cycle after address taken
  always_comb begin
    logic       ok;
    logic [3:0] ridx;
    ok          = 1'b0;
    ridx        = decode(s_axi_araddr, ok);
    next_rvalid = rvalid;
    next_rdata  = rdata;
    next_rresp  = rresp;
    if (s_axi_arvalid && !rvalid) begin
      next_rvalid = 1'b1;
      next_rdata  = ok ? regs[ridx] : `RESET_ZERO;
      next_rresp  = ok ? 2'b00 : 2'b10;
    end else if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    next_ar_free = !next_rvalid;
  end

  // raster counters; left to software
  always_comb begin
    next_hcount = hcount + 11'd1;
    next_vcount = vcount;
    next_faddr  = faddr;
    if (next_hcount >= htot) begin
      next_hcount = 11'd0;
      next_vcount = (vcount + 11'd1 >= vtot) ? 11'd0 : vcount + 11'd1;
    end
    next_de = (hcount >= hds) && (hcount < hds + horiz_display_period) && (vcount >= vds) && (vcount < vds + vert_display_period);
    // step on the shown flag itself, so the first shown clock carries the start word
    if (hcount == 11'd0 && vcount == 11'd0) begin
      next_faddr = regs[8][16:0];
    end else if (de) begin
      next_faddr = faddr + 17'd1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 11; i++) begin
        regs[i] <= `RESET_ZERO;
      end
      aw_addr <= 8'h00;
      w_data  <= `RESET_ZERO;
      w_strb  <= 4'h0;
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= 2'b00;
      rvalid  <= 1'b0;
      rdata   <= `RESET_ZERO;
      rresp   <= 2'b00;
      hcount  <= 11'd0;
      vcount  <= 11'd0;
      de      <= 1'b0;
      faddr   <= 17'h0_0000;
      aw_free <= 1'b1;
      w_free  <= 1'b1;
      ar_free <= 1'b1;
    end else begin
      for (int i = 0; i < 11; i++) begin
        regs[i] <= next_regs[i];
      end
      aw_addr <= next_aw_addr;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      aw_held <= next_aw_held;
      w_held  <= next_w_held;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      rvalid  <= next_rvalid;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
      hcount  <= next_hcount;
      vcount  <= next_vcount;
      de      <= next_de;
      faddr   <= next_faddr;
      aw_free <= next_aw_free;
      w_free  <= next_w_free;
      ar_free <= next_ar_free;
    end
  end

  // tft type two and three drive the line sync active high regardless
  sync_pulse u_line (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .pos         (hcount),
    .first       (line_sync_start),
    .len         (line_sync_width),
    .active_high (hpol || ptype == panel_timing_pkg::PANEL_TFT2 ||
                  ptype == panel_timing_pkg::PANEL_TFT3),
    .pulse       (line_raw)
  );
  sync_pulse u_frame (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .pos         (vcount),
    .first       (frame_sync_start),
    .len         (vpw),
    .active_high (vpol),
    .pulse       (frame_raw)
  );

  always_comb begin
    s_axi_awready     = aw_free;
    s_axi_wready      = w_free;
    s_axi_bvalid      = bvalid;
    s_axi_bresp       = bresp;
    s_axi_arready     = ar_free;
    s_axi_rvalid      = rvalid;
    s_axi_rdata       = rdata;
    s_axi_rresp       = rresp;
    line_sync_output  = line_raw;
    frame_sync_output = frame_raw;
    display_enable    = de;
    fetch_address     = faddr;
  end

  chk_frame_addr_load: assert property (@(posedge aclk) disable iff (!aresetn)
    (hcount == 11'd0 && vcount == 11'd0) |=> (faddr == $past(regs[8][16:0])))
    else $error("fetch address not loaded at frame start");
  chk_line_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
    (hcount + 11'd1 >= htot) |=> (hcount == 11'd0))
    else $error("line counter did not wrap at total");
  chk_frame_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
    (hcount + 11'd1 >= htot && vcount + 11'd1 >= vtot) |=> (vcount == 11'd0))
    else $error("frame counter did not wrap at total");
  chk_line_start: assert property (@(posedge aclk) disable iff (!aresetn)
    (hcount == line_sync_start) |=> (line_raw == $past(hpol || ptype[1])))
    else $error("line sync not active at start position");
  chk_line_width: assert property (@(posedge aclk) disable iff (!aresetn)
    (hcount == line_sync_start + line_sync_width && line_sync_start + line_sync_width < htot) |=> (line_raw != $past(hpol || ptype[1])))
    else $error("line sync width wrong");
  chk_tft2_pol: assert property (@(posedge aclk) disable iff (!aresetn)
    (ptype[1] && hcount == line_sync_start) |=> line_raw)
    else $error("polarity affected tft type two or three");
  chk_line_pol: assert property (@(posedge aclk) disable iff (!aresetn)
    (hcount == line_sync_start && !ptype[1]) |=> (line_raw == $past(hpol)))
    else $error("line sync level does not follow polarity bit");
  chk_frame_start: assert property (@(posedge aclk) disable iff (!aresetn)
    (vcount == frame_sync_start) |=> (frame_raw == $past(vpol)))
    else $error("frame sync not active at start line");
  chk_frame_width: assert property (@(posedge aclk) disable iff (!aresetn)
    (vcount >= frame_sync_start + vpw && frame_sync_start + vpw < vtot) |=> (frame_raw != $past(vpol)))
    else $error("frame sync beyond width");
  chk_de_period: assert property (@(posedge aclk) disable iff (!aresetn)
    (hcount >= hds + horiz_display_period) |=> !de)
    else $error("display enable past display period");
  chk_vdisp: assert property (@(posedge aclk) disable iff (!aresetn)
    (vcount >= vds + vert_display_period) |=> !de)
    else $error("display enable past vertical period");
  chk_de_start: assert property (@(posedge aclk) disable iff (!aresetn)
    (hcount == hds && vcount >= vds && vcount < vds + vert_display_period) |=> de)
    else $error("display enable missing at window start");
  chk_addr_step: assert property (@(posedge aclk) disable iff (!aresetn)
    (de && !(hcount == 11'd0 && vcount == 11'd0)) |=> (faddr == $past(faddr) + 17'd1))
    else $error("fetch address did not step on shown clock");
  chk_addr_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (!de && !(hcount == 11'd0 && vcount == 11'd0)) |=> (faddr == $past(faddr)))
    else $error("fetch address moved outside the window");
endmodule // panel_timing
`default_nettype wire

/* File: hw/panel_timing_defines.svh */
// constants for the panel timing generator
`ifndef PANEL_TIMING_DEFINES_SVH
`define PANEL_TIMING_DEFINES_SVH
`define OFS_HTOTAL      8'h20
`define OFS_HDISP       8'h24
`define OFS_HSTART      8'h28
`define OFS_LINE_SYNC   8'h2c
`define OFS_VTOTAL      8'h30
`define OFS_VDISP       8'h34
`define OFS_VSTART      8'h38
`define OFS_FRAME_SYNC  8'h3c
`define OFS_MAIN_ADDR   8'h40
`define OFS_PANEL_CTRL  8'h4c
`define OFS_STATUS      8'h50
`define POL_BIT         23
`define PIX_PER_UNIT    3
`define RESET_ZERO      32'h0000_0000
`endif

/* File: hw/panel_timing_pkg.sv */
// types for the panel timing generator
package panel_timing_pkg;
  typedef enum logic [1:0] {
    PANEL_PASSIVE = 2'b00,
    PANEL_TFT     = 2'b01,
    PANEL_TFT2    = 2'b11,
    PANEL_TFT3    = 2'b10
  } panel_e;
endpackage

/* File: hw/sync_pulse.sv */
// one sync pulse generator against a position counter
`timescale 1ns/1ns
`default_nettype none
module sync_pulse (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [10:0] pos,
  input  wire logic [10:0] first,
  input  wire logic [10:0] len,
  input  wire logic        active_high,
  output logic             pulse
);
  logic        next_pulse;
  logic [11:0] end_pos;
  always_comb begin
    end_pos    = {1'b0, first} + {1'b0, len};
    next_pulse = (({1'b0, pos} >= {1'b0, first}) && ({1'b0, pos} < end_pos)) == active_high;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pulse <= 1'b1;
    end else begin
      pulse <= next_pulse;
    end
  end
endmodule // sync_pulse
`default_nettype wire

/* File: testbench/panel_model.sv */
// panel side model: measures sync period and active width
`timescale 1ns/1ns
`default_nettype none
module panel_model (
  input  wire logic aclk,
  input  wire logic sync,
  input  wire logic act_high,
  output var  int   period,
  output var  int   width
);
  logic act;
  logic prev = 0;
  int   cnt  = 0;
  int   run  = 0;
  // panel is wired for one level, like a real glass
  assign act = act_high ? sync : ~sync;
  always_ff @(posedge aclk) begin
    prev <= act;
    cnt  <= cnt + 1;
    if (act) run <= run + 1;
    if (act && !prev) begin
      period <= cnt;
      cnt    <= 1;
      run    <= 1;
    end
    if (!act && prev) width <= run;
  end
endmodule // panel_model
`default_nettype wire

/* File: testbench/panel_timing_tb_top.sv */
// testbench for the panel timing generator
`timescale 1ns/1ns
`default_nettype none
module panel_timing_tb_top;
  localparam logic [7:0]  OFS [9] = '{8'h20, 8'h24, 8'h28, 8'h2c, 8'h30,
                                      8'h34, 8'h38, 8'h3c, 8'h40};
  // small legal timing: 32 px line, 16 px shown, 10 lines
  localparam logic [31:0] CFG [9] = '{32'h0000_0003, 32'h0000_0001, 32'h0000_0002,
                                      32'h0082_0004, 32'h0000_0009, 32'h0000_0005,
                                      32'h0000_0001, 32'h0081_0000, 32'h0000_0123};
  logic        aclk = 0;
  logic        aresetn = 0;
  logic [7:0]  awaddr = 0;
  logic [7:0]  araddr = 0;
  logic [31:0] wdata = 0;
  logic [3:0]  wstrb = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        lsync, fsync, de;
  logic        lpol = 1;
  logic [16:0] faddr;
  int          n_fail = 0, tests_run = 0, cyc = 0;
  int          lper, lwid, fper, fwid, dwid;
  logic [31:0] exp_reg [9];

  panel_timing i_panel_timing (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .line_sync_output(lsync), .frame_sync_output(fsync),
    .display_enable(de), .fetch_address(faddr));
  panel_model i_line (.aclk(aclk), .sync(lsync), .act_high(lpol), .period(lper), .width(lwid));
  panel_model i_frame (.aclk(aclk), .sync(fsync), .act_high(1'b1), .period(fper), .width(fwid));
  panel_model i_de (.aclk(aclk), .sync(de), .act_high(1'b1), .period(), .width(dwid));

  initial begin
    forever #50 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      conclude();
    end
  end

  task automatic conclude();
    if (n_fail == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] expct);
    tests_run++;
    if (seen !== expct) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, expct);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad, dd;
    ad = 0;
    dd = 0;
    @(posedge aclk);
    awaddr <= a; wdata <= d; wstrb <= 4'hf; awvalid <= 1; wvalid <= 1; bready <= 1;
    while (!(ad && dd)) begin
      @(posedge aclk);
      if (awready && !ad) begin ad = 1; awvalid <= 0; end
      if (wready && !dd) begin dd = 1; wvalid <= 0; end
    end
    while (!bvalid) @(posedge aclk);
    bready <= 0;
    check(32'(bresp), 32'(er));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    while (!rvalid) @(posedge aclk);
    rready <= 0;
    check(rdata, ex);
    check(32'(rresp), 32'(er));
  endtask

  initial begin
    logic [31:0] v;
    v = $urandom(73548);
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    for (int k = 0; k < 9; k++) rd(OFS[k], 32'h0000_0000, 2'b00);
    for (int k = 0; k < 9; k++) begin
      v = $urandom();
      exp_reg[k] = v;
      wr(OFS[k], v, 2'b00);
    end
    for (int k = 0; k < 9; k++) rd(OFS[k], exp_reg[k], 2'b00);
    // unmapped place answers with a slave error
    rd(8'h04, 32'h0000_0000, 2'b10);
    wr(8'h04, $urandom(), 2'b10);
    wr(8'h50, $urandom(), 2'b00);
    wr(8'h4c, 32'h0000_0001, 2'b00);
    for (int k = 0; k < 9; k++) wr(OFS[k], CFG[k], 2'b00);
    repeat (700) @(posedge aclk);
    check(lper, 32);
    check(lwid, 3);
    check(dwid, 16);
    check(fper, 320);
    check(fwid, 64);
    do @(posedge aclk); while (fsync);
    do @(posedge aclk); while (!fsync);
    do @(posedge aclk); while (!de);
    check(32'(faddr), 32'h0000_0123);
    lpol <= 0;
    wr(8'h2c, 32'h0002_0004, 2'b00);
    repeat (700) @(posedge aclk);
    check(lwid, 3);
    lpol <= 1;
    wr(8'h4c, 32'h0000_0003, 2'b00);
    repeat (700) @(posedge aclk);
    check(lwid, 3);
    check(lper, 32);
    wr(8'h4c, 32'h0000_0002, 2'b00);
    repeat (700) @(posedge aclk);
    check(lwid, 3);
    // passive glass: 64 px line, 32 px shown, display start fields zero
    wr(8'h4c, 32'h0000_0000, 2'b00);
    wr(8'h2c, 32'h0082_0004, 2'b00);
    wr(8'h28, 32'h0000_0000, 2'b00);
    wr(8'h38, 32'h0000_0000, 2'b00);
    wr(8'h24, 32'h0000_0003, 2'b00);
    wr(8'h20, 32'h0000_0007, 2'b00);
    repeat (1400) @(posedge aclk);
    check(lper, 64);
    check(dwid, 32);
    check(fper, 640);
    check(fwid, 128);
    check(lwid, 3);
    conclude();
  end
endmodule // panel_timing_tb_top
`default_nettype wire
